/* src/clpr_defines.vh */
// Constants for the control list pointer registers.
// Assumes a host register port with byte offsets from the memory base.
// Overview of operation
// [RQ1] Head pointer register sits at offset 20h; pointer field is bits 31:4.
// [RQ2] Head register holds first descriptor address, 28 bits; bits 3:0 reserved.
// [RQ3] Control list walking starts at the address held in the head register.
// [RQ4] At initialization the head value is loaded from the shared comm area.
// [RQ5] Current pointer register sits at offset 24h; top field bits 27:20; the code uses a pointer field over bits 31:4.
// [RQ6] Current register holds the descriptor address being processed now.
// [RQ7] Shared comm area base is 256-byte aligned; its low 8 bits are zero.
// [RQ8] Current register is updated at each move to the next descriptor.
`ifndef CLPR_DEFINES_VH
`define CLPR_DEFINES_VH

`define CLPR_HEAD_OFS       8'h20
`define CLPR_CURR_OFS       8'h24
`define CLPR_PTR_LSB        4
`define CLPR_PTR_MSB        31
`define CLPR_PTR_W          28
`define CLPR_HEAD_RST       28'h0000000
`define CLPR_CURR_RST       28'h0000000
`define CLPR_COMM_ALIGN_W   8
`define CLPR_COMM_HEAD_OFS  32'h00000000
`define CLPR_NEXT_PTR_OFS   32'h0000000C

`endif

/* src/clpr_ptr_reg.v */
// One descriptor pointer register: 28-bit field over bits 31:4.
// Assumes loads come from logic on clk_sys.
`timescale 1ns/1ps
module clpr_ptr_reg #(
  parameter [27:0] RST_VAL = 28'h0000000
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        load,
  input  wire [31:0] loadValue,
  output wire [31:0] regValue
);
  reg [27:0] ptr_q;

  // Reserved low bits are dropped on load and read as zero
  always @(posedge clk_sys) begin
    if (rst) begin
      ptr_q <= RST_VAL;
    end else if (load) begin
      ptr_q <= loadValue[31:4]; // RQ2
    end
  end

  assign regValue = {ptr_q, 4'h0}; // RQ2

endmodule // clpr_ptr_reg

/* src/clpr_top.v */
// Control list head and current pointer registers with list walker.
// Assumes a one-read-at-a-time system memory port and a host read port.
`timescale 1ns/1ps
`include "clpr_defines.vh"
module clpr_top #(
  parameter [31:0] COMM_HEAD_OFS = `CLPR_COMM_HEAD_OFS,
  parameter [31:0] NEXT_PTR_OFS  = `CLPR_NEXT_PTR_OFS
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        regRd,
  input  wire [7:0]  regAddr,
  output reg  [31:0] regRdData,
  output reg         regRdValid,
  input  wire        initStart,
  input  wire [31:0] commAreaBase,
  input  wire        walkStart,
  output wire        memRdReq,
  output reg  [31:0] memRdAddr,
  input  wire        memRdAck,
  input  wire [31:0] memRdData,
  output reg         descVisit,
  output wire [31:0] descAddr,
  output wire        walkBusy,
  output wire        initBusy
);
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_INIT = 2'b01;
  localparam [1:0] ST_WALK = 2'b10;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [31:0] addr_d;
  reg         visit_d;
  reg         headLoad;
  reg         currLoad;
  reg  [31:0] currValue;
  wire [31:0] headReg;
  wire [31:0] currReg;
  wire [31:0] commAligned;
  wire [31:0] nextPtr;

  // Shared comm area base low bits forced to zero
  assign commAligned = {commAreaBase[31:8], 8'h00}; // RQ7
  assign nextPtr     = {memRdData[31:4], 4'h0};

  clpr_ptr_reg #(
    .RST_VAL   (`CLPR_HEAD_RST)
  ) u_head (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .load      (headLoad),
    .loadValue (memRdData),
    .regValue  (headReg)
  );

  clpr_ptr_reg #(
    .RST_VAL   (`CLPR_CURR_RST)
  ) u_curr (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .load      (currLoad),
    .loadValue (currValue),
    .regValue  (currReg)
  );

  // Walker and init sequencer
  always @* begin
    state_d   = state_q;
    addr_d    = memRdAddr;
    visit_d   = 1'b0;
    headLoad  = 1'b0;
    currLoad  = 1'b0;
    currValue = headReg;
    case (state_q)
      ST_IDLE: begin
        if (initStart) begin
          state_d = ST_INIT;
          addr_d  = commAligned + COMM_HEAD_OFS; // RQ4
        end else if (walkStart) begin
          currLoad  = 1'b1;
          currValue = headReg; // RQ3
          if (headReg != 32'h00000000) begin
            state_d = ST_WALK;
            visit_d = 1'b1;
            addr_d  = headReg + NEXT_PTR_OFS;
          end
        end
      end
      ST_INIT: begin
        if (memRdAck) begin
          headLoad = 1'b1; // RQ4
          state_d  = ST_IDLE;
        end
      end
      ST_WALK: begin
        if (memRdAck) begin
          currLoad  = 1'b1; // RQ8
          currValue = nextPtr; // RQ6
          if (nextPtr == 32'h00000000) begin
            state_d = ST_IDLE;
          end else begin
            visit_d = 1'b1;
            addr_d  = nextPtr + NEXT_PTR_OFS;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      memRdAddr <= 32'h00000000;
      descVisit <= 1'b0;
    end else begin
      state_q   <= state_d;
      memRdAddr <= addr_d;
      descVisit <= visit_d;
    end
  end

  assign memRdReq = (state_q != ST_IDLE);
  assign walkBusy = (state_q == ST_WALK);
  assign initBusy = (state_q == ST_INIT);
  assign descAddr = currReg;

  // Host read port, unmapped offsets read zero
  always @(posedge clk_sys) begin
    if (rst) begin
      regRdData  <= 32'h00000000;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRd;
      if (regRd) begin
        case (regAddr)
          `CLPR_HEAD_OFS: begin
            regRdData <= headReg; // RQ1
          end
          `CLPR_CURR_OFS: begin
            regRdData <= currReg; // RQ5
          end
          default: begin
            regRdData <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule // clpr_top

/* bench/clpr_props.sv */
// Checker for the control list pointer block ports.
// Assumes binding into clpr_top on clk_sys.
`timescale 1ns/1ps
module clpr_props #(
  parameter [31:0] COMM_HEAD_OFS = 32'h0,
  parameter [31:0] NEXT_PTR_OFS  = 32'hC
) (
  input wire        clk_sys,
  input wire        rst,
  input wire        regRd,
  input wire [7:0]  regAddr,
  input wire [31:0] regRdData,
  input wire        regRdValid,
  input wire        initStart,
  input wire [31:0] commAreaBase,
  input wire        walkBusy,
  input wire        initBusy,
  input wire [31:0] memRdAddr,
  input wire        memRdAck,
  input wire [31:0] memRdData,
  input wire        descVisit,
  input wire [31:0] descAddr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_rd_valid: assert property (regRd |=> regRdValid)
    else $error("read not answered");
  a_rsvd_low: assert property (regRdValid |-> regRdData[3:0] == 4'h0)
    else $error("reserved bits set");
  a_unmapped_zero: assert property (regRd && regAddr != 8'h20 &&
    regAddr != 8'h24 |=> regRdData == 32'h0) else $error("unmapped read");
  a_walk_begin: assert property ($rose(walkBusy) |-> descVisit &&
    memRdAddr == descAddr + NEXT_PTR_OFS) else $error("walk start");
  a_init_addr: assert property (initStart && !walkBusy && !initBusy
    |=> initBusy && memRdAddr == {$past(commAreaBase[31:8]), 8'h00}
    + COMM_HEAD_OFS) else $error("init address");
  a_cur_low: assert property (descAddr[3:0] == 4'h0)
    else $error("current low bits");
  a_cur_read: assert property (regRd && regAddr == 8'h24 |=>
    regRdData == $past(descAddr)) else $error("current read");
  a_step_load: assert property (walkBusy && memRdAck |=>
    descAddr == {$past(memRdData[31:4]), 4'h0}) else $error("step load");
  a_step_visit: assert property (walkBusy && memRdAck &&
    memRdData[31:4] != 28'h0 |=> descVisit) else $error("no visit");
endmodule // clpr_props
bind clpr_top clpr_props #(.COMM_HEAD_OFS(COMM_HEAD_OFS),
  .NEXT_PTR_OFS(NEXT_PTR_OFS)) u_props (.*);

/* bench/clpr_top_tb.sv */
// Testbench for the control list pointer block.
// Assumes clpr_top and its checker are compiled alongside.
`timescale 1ns/1ps
module clpr_top_tb;
  reg         clk_sys = 0, rst = 1, regRd = 0, memRdAck = 0;
  reg         initStart = 0, walkStart = 0;
  reg  [7:0]  regAddr = 8'h00;
  reg  [31:0] commAreaBase = 32'h0, memRdData = 32'h0;
  wire [31:0] regRdData, memRdAddr, descAddr;
  wire        regRdValid, memRdReq, descVisit, walkBusy, initBusy;
  integer     n_mismatch = 0, n_tests = 0, cyc = 0;
  clpr_top i_dut (.*);
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 500) begin
      n_mismatch = n_mismatch + 1;
      results;
    end
  end
  task tick;
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      regRd = 1;
      regAddr = a;
      tick;
      regRd = 0;
      chk("regRdData", regRdData, e);
      chk("regRdValid", regRdValid, 1'b1);
      tick;
      chk("regRdValidLow", regRdValid, 1'b0);
    end
  endtask
  task mem(input [31:0] a, input [31:0] d);
    integer i;
    begin
      for (i = 0; i < 50 && memRdReq !== 1'b1; i = i + 1) tick;
      chk("memRdAddr", memRdAddr, a);
      memRdData = d;
      memRdAck = 1;
      tick;
      memRdAck = 0;
      memRdData = ~d;
      tick;
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (4) tick;
    rst = 0;
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h0);
    rd(8'h28, 32'h0);
    $display("reset reads done");
    commAreaBase = 32'h12345678;
    initStart = 1;
    tick;
    initStart = 0;
    chk("initBusy", initBusy, 1'b1);
    chk("memRdReq", memRdReq, 1'b1);
    mem(32'h12345600, 32'h0000123F);
    chk("initDone", initBusy, 1'b0);
    rd(8'h20, 32'h00001230);
    walkStart = 1;
    tick;
    walkStart = 0;
    chk("walkBusy", walkBusy, 1'b1);
    chk("descVisit", descVisit, 1'b1);
    chk("descAddr", descAddr, 32'h00001230);
    mem(32'h0000123C, 32'h00002005);
    rd(8'h24, 32'h00002000);
    mem(32'h0000200C, 32'h0);
    chk("walkEnd", walkBusy, 1'b0);
    rd(8'h24, 32'h0);
    $display("init and walk done");
    results;
  end
endmodule // clpr_top_tb
